/* mtef_pkg.sv */
// Function
// - entry data bits 46:43 are reserved, read zero, writes ignored
// - physical addresses are 43 bits; cache tags keep bits 42:6
// - cacheable access at or above the limit misses L2, goes out, flags
// - width select picks 41 or 43 bus address bits
// - 41-bit mode with nonzero dropped bits flags after the transfer
// - data access read returns page offset bits as written
// - locked entries go to the full TLB; others by page size
// - set-associative TLBs hold no lock bit
// - no TLB holds the cache-virtual bit
// - size exponent is 4 bits; hash comes from the context id
// - common buffer holds at most 16 million lines
// - hash mode takes the base straight from the extension register
// - hash-mode pointers join extension, hashed virtual index and four zeros
// - misaligned jump-and-link or return leaves data fault state alone
// - instruction access error traps and updates instruction fault status
// - data access error traps and updates data fault status and address
// - tag access context is undefined after a data access exception
// - multiple hits count only when the micro TLB misses
`default_nettype none
package mtef_pkg;
  localparam int unsigned DW      = 64;
  localparam int unsigned PAW     = 43;
  localparam int unsigned NAW     = 41;
  localparam int unsigned TAG_LO  = 6;
  localparam logic [PAW-1:0] PA_LIMIT = 43'h400_0000_0000;
  // entry data fields
  localparam int unsigned RSV_HI  = 46;
  localparam int unsigned RSV_LO  = 43;
  localparam int unsigned SZ_LO   = 61;
  localparam int unsigned LOCK_B  = 6;
  localparam int unsigned CV_B    = 4;
  localparam logic [1:0] SZ_64K   = 2'h1;
  localparam logic [1:0] SZ_512K  = 2'h2;
  // pointer formation
  localparam int unsigned SZW     = 4;
  localparam int unsigned CTXW    = 13;
  localparam int unsigned IDX_BASE = 9;
  localparam int unsigned VA8_LO  = 13;
  localparam int unsigned VA64_LO = 16;
  localparam int unsigned PTR_LO  = 4;
  localparam int unsigned MAX_LINES_LOG2 = 24;
  // register index map
  localparam logic [3:0] A_CTRL  = 4'h0;
  localparam logic [3:0] A_BASE  = 4'h1;
  localparam logic [3:0] A_EXT   = 4'h2;
  localparam logic [3:0] A_CTX   = 4'h3;
  localparam logic [3:0] A_ISTAT = 4'h4;
  localparam logic [3:0] A_DSTAT = 4'h5;
  localparam logic [3:0] A_DFAR  = 4'h6;
  localparam logic [3:0] A_IRQ   = 4'h7;
  localparam logic [3:0] A_MASK  = 4'h8;
  localparam logic [3:0] A_SEL   = 4'h9;
  localparam logic [3:0] A_TLBD  = 4'hA;
  // control fields
  localparam int unsigned C_AW   = 0;
  localparam int unsigned C_HM   = 1;
  localparam int unsigned C_SZ   = 2;
  localparam int unsigned CTRL_W = 6;
  // interrupt bits
  localparam int unsigned IRQ_W   = 3;
  localparam int unsigned IRQ_IAE = 0;
  localparam int unsigned IRQ_DAE = 1;
  localparam int unsigned IRQ_BAD = 2;
  // fault status: cause bits 4:0, trap type 16:8
  localparam int unsigned CSW    = 5;
  localparam int unsigned TT_LO  = 8;
  localparam logic [8:0] TT_IAE  = 9'h00A;
  localparam logic [8:0] TT_DAE  = 9'h032;
  localparam logic [8:0] TT_MIS  = 9'h034;
  // tlb select fields
  localparam int unsigned S_SIDE = 0;
  localparam int unsigned S_FA   = 1;
  localparam int unsigned S_IDX  = 2;
endpackage
`default_nettype wire

/* mtef_ptr_if.sv */
`default_nettype none
interface mtef_ptr_if;
  logic [63:0] ext;
  logic [63:0] base;
  logic [63:0] va;
  logic [12:0] ctx;
  logic [3:0]  size;
  logic        hmode;
  logic [63:0] p8;
  logic [63:0] p64;
  modport former (input ext, base, va, ctx, size, hmode, output p8, p64);
  modport user   (output ext, base, va, ctx, size, hmode, input p8, p64);
endinterface
`default_nettype wire

/* mtef_ptr_form.sv */
`default_nettype none
module mtef_ptr_form (
  mtef_ptr_if.former pif
);
  // ---------------------------------------------------------------
  // buffer pointer formation
  // ---------------------------------------------------------------
  logic [63:0] idx_mask;
  logic [63:0] base_mask;
  logic [63:0] hash;
  logic [63:0] tbase;
  logic [63:0] i8;
  logic [63:0] i64;
  // index is 9+N bits wide, N up to 15 keeps 2^24 lines max
  assign idx_mask  = ~(64'hFFFF_FFFF_FFFF_FFFF <<
                     (mtef_pkg::IDX_BASE + 32'(pif.size)));
  assign base_mask = ~(idx_mask << mtef_pkg::PTR_LO);
  // hash from context id only in hash mode
  assign hash  = pif.hmode ? 64'(pif.ctx) : 64'h0;
  assign tbase = pif.hmode ? pif.ext : (pif.base ^ pif.ext);
  assign i8  = ((pif.va >> mtef_pkg::VA8_LO) ^ hash) & idx_mask;
  assign i64 = ((pif.va >> mtef_pkg::VA64_LO) ^ hash) & idx_mask;
  // tbase above (extension in hash mode), index (hashed in hash mode), four zero bits
  assign pif.p8  = (tbase & base_mask & ~64'hF) |
                   (i8 << mtef_pkg::PTR_LO);
  assign pif.p64 = (tbase & base_mask & ~64'hF) |
                   (i64 << mtef_pkg::PTR_LO);
endmodule
`default_nettype wire

/* mtef_mmu.sv */
`default_nettype none
module mtef_mmu #(
  parameter int unsigned FA_N = 32,
  parameter int unsigned SA_N = 2048
) (
  // clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_n_i,
  // register port
  input  wire logic [3:0]               reg_addr_i,
  input  wire logic [63:0]              reg_wdata_i,
  input  wire logic                     reg_we_i,
  input  wire logic                     reg_re_i,
  output logic      [63:0]              reg_rdata_o,
  // entry data-in write, side 0 instr 1 data
  input  wire logic                     tte_wr_i,
  input  wire logic                     tte_side_i,
  input  wire logic [$clog2(SA_N)-1:0]  tte_idx_i,
  input  wire logic [63:0]              tte_data_i,
  // physical request toward the bus
  input  wire logic                     req_valid_i,
  input  wire logic [42:0]              req_pa_i,
  input  wire logic                     req_cacheable_i,
  input  wire logic                     l2_hit_i,
  output logic                          bus_req_o,
  output logic      [42:0]              bus_addr_o,
  output logic                          bus_cacheable_o,
  output logic      [36:0]              l2_tag_o,
  // error sources
  input  wire logic                     i_ue_i,
  input  wire logic                     i_buserr_i,
  input  wire logic                     i_multi_i,
  input  wire logic                     i_utlb_hit_i,
  input  wire logic                     i_parity_i,
  input  wire logic                     d_ue_i,
  input  wire logic                     d_buserr_i,
  input  wire logic                     d_multi_i,
  input  wire logic                     d_utlb_hit_i,
  input  wire logic                     d_parity_i,
  input  wire logic [63:0]              d_va_i,
  input  wire logic                     d_misalign_i,
  input  wire logic                     d_jump_and_link_instr_ret_i,
  // traps and interrupt
  output logic                          iae_trap_o,
  output logic                          dae_trap_o,
  output logic                          irq_o,
  // pointer formation
  input  wire logic [63:0]              va_i,
  output logic      [63:0]              ptr8k_o,
  output logic      [63:0]              ptr64k_o
);
  localparam int unsigned FAW = $clog2(FA_N);
  localparam int unsigned SAW = $clog2(SA_N);

  if (FA_N < 2 || SA_N < 2 || (1 << FAW) != FA_N) begin : g_chk
    $error("FA_N and SA_N must be at least 2, FA_N a power of two");
  end

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction

  logic [5:0]  ctrl;
  logic [63:0] tbase;
  logic [63:0] text;
  logic [12:0] ctx;
  logic [16:0] istat;
  logic [16:0] dstat;
  logic [63:0] dfar;
  logic [2:0]  irq_st;
  logic [2:0]  irq_mask;
  logic [63:0] sel;
  wire w_ctrl = reg_we_i & hit(reg_addr_i, mtef_pkg::A_CTRL);
  wire w_base = reg_we_i & hit(reg_addr_i, mtef_pkg::A_BASE);
  wire w_ext  = reg_we_i & hit(reg_addr_i, mtef_pkg::A_EXT);
  wire w_ctx  = reg_we_i & hit(reg_addr_i, mtef_pkg::A_CTX);
  wire w_irq  = reg_we_i & hit(reg_addr_i, mtef_pkg::A_IRQ);
  wire w_mask = reg_we_i & hit(reg_addr_i, mtef_pkg::A_MASK);
  wire w_sel  = reg_we_i & hit(reg_addr_i, mtef_pkg::A_SEL);
  wire aw43   = ctrl[mtef_pkg::C_AW];

  // software-owned settings; width select loads 43-bit at reset, changes only on a control write
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl <= 6'h01;
      tbase <= 64'h0;
      text <= 64'h0;
      ctx <= 13'h0;
      irq_mask <= 3'h0;
      sel <= 64'h0;
    end else begin
      if (w_ctrl) ctrl <= reg_wdata_i[5:0];
      if (w_base) tbase <= reg_wdata_i;
      if (w_ext) text <= reg_wdata_i;
      if (w_ctx) ctx <= reg_wdata_i[12:0];
      if (w_mask) irq_mask <= reg_wdata_i[2:0];
      if (w_sel) sel <= reg_wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // entry storage
  // ---------------------------------------------------------------
  logic [63:0]    fa_q [2][FA_N];
  logic [63:0]    sa_q [2][SA_N];
  logic [FAW-1:0] fa_ptr [2];
  wire  [63:0] keep_m = ~((64'h1 << mtef_pkg::CV_B) |
                          (64'hF << mtef_pkg::RSV_LO));
  wire  [63:0] wd     = tte_data_i & keep_m;
  wire  [1:0]  pgsz   = tte_data_i[mtef_pkg::SZ_LO +: 2];
  // locked or mid-size pages only fit the full TLB
  wire to_fa = tte_data_i[mtef_pkg::LOCK_B] |
               (pgsz == mtef_pkg::SZ_64K) |
               (pgsz == mtef_pkg::SZ_512K);
  wire [63:0] sa_wd = wd & ~(64'h1 << mtef_pkg::LOCK_B);

  for (genvar g = 0; g < 2; g++) begin : g_side
    wire wr = tte_wr_i & (tte_side_i == 1'(g));
    // round-robin placement; the real policy lives elsewhere
    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        fa_ptr[g] <= '0;
      end else if (wr & to_fa) begin
        fa_q[g][fa_ptr[g]] <= wd;
        fa_ptr[g] <= fa_ptr[g] + 1'b1;
      end
    end
    always_ff @(posedge ref_clk_i) begin
      if (wr & ~to_fa) begin
        sa_q[g][tte_idx_i] <= sa_wd;
      end
    end
  end

  wire          s_side = sel[mtef_pkg::S_SIDE];
  wire [63:0]   s_fa   = fa_q[s_side][sel[mtef_pkg::S_IDX +: FAW]];
  wire [63:0]   s_sa   = sa_q[s_side][sel[mtef_pkg::S_IDX +: SAW]];
  // offsets come back as written, never forced to zero
  wire [63:0]   tlb_rd = sel[mtef_pkg::S_FA] ? s_fa : s_sa;

  // ---------------------------------------------------------------
  // bus address path
  // ---------------------------------------------------------------
  logic bad_pend;
  wire  over = req_cacheable_i & (req_pa_i >= mtef_pkg::PA_LIMIT);
  wire  drop = ~aw43 & (|req_pa_i[42:41]);
  // high cacheable addresses never hit L2, always go out cacheable
  wire  issue = req_valid_i & (~req_cacheable_i | ~l2_hit_i | over);
  wire [42:0] out_a = aw43 ? req_pa_i
                           : {2'b00, req_pa_i[40:0]};

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bus_req_o <= 1'b0;
      bus_addr_o <= 43'h0;
      bus_cacheable_o <= 1'b0;
      bad_pend <= 1'b0;
    end else begin
      bus_req_o <= issue;
      if (issue) bus_addr_o <= out_a;
      if (issue) bus_cacheable_o <= req_cacheable_i;
      bad_pend <= issue & (over | drop);
    end
  end

  // cache tag keeps physical bits 42:6
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) l2_tag_o <= 37'h0;
    else if (req_valid_i) l2_tag_o <= req_pa_i[42:mtef_pkg::TAG_LO];
  end

  // ---------------------------------------------------------------
  // fault recording
  // ---------------------------------------------------------------
  // micro TLB hit hides main TLB multiple hits
  wire i_mh = i_multi_i & ~i_utlb_hit_i;
  wire d_mh = d_multi_i & ~d_utlb_hit_i;
  wire [4:0] i_cs = {1'b0, i_parity_i, i_mh, i_buserr_i, i_ue_i};
  wire [4:0] d_cs = {1'b0, d_parity_i, d_mh, d_buserr_i, d_ue_i};
  wire i_err = |i_cs;
  wire d_err = |d_cs;
  // jump-and-link or return misalign leaves data fault state
  wire d_mis = d_misalign_i & ~d_jump_and_link_instr_ret_i;
  wire [4:0] mis_cs = 5'h10;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      istat <= 17'h0;
      iae_trap_o <= 1'b0;
    end else begin
      iae_trap_o <= i_err;
      if (i_err) istat <= {mtef_pkg::TT_IAE, 3'h0, i_cs};
    end
  end

  // tag access context is not tracked here at all
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      dstat <= 17'h0;
      dfar <= 64'h0;
      dae_trap_o <= 1'b0;
    end else begin
      dae_trap_o <= d_err;
      if (d_err) begin
        dstat <= {mtef_pkg::TT_DAE, 3'h0, d_cs};
        dfar <= d_va_i;
      end else if (d_mis) begin
        dstat <= {mtef_pkg::TT_MIS, 3'h0, mis_cs};
        dfar <= d_va_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, write one to clear, set wins
  // ---------------------------------------------------------------
  wire [2:0] irq_set = {bad_pend, d_err, i_err};
  wire [2:0] irq_clr = w_irq ? reg_wdata_i[2:0] : 3'h0;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_st <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      irq_st <= (irq_st & ~irq_clr) | irq_set;
      irq_o <= |(((irq_st & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // pointer formation
  // ---------------------------------------------------------------
  mtef_ptr_if pif ();
  assign pif.ext   = text;
  assign pif.base  = tbase;
  assign pif.va    = va_i;
  assign pif.ctx   = ctx;
  assign pif.size  = ctrl[mtef_pkg::C_SZ +: mtef_pkg::SZW];
  assign pif.hmode = ctrl[mtef_pkg::C_HM];

  mtef_ptr_form u_ptr (
    .pif (pif.former)
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ptr8k_o <= 64'h0;
      ptr64k_o <= 64'h0;
    end else begin
      ptr8k_o <= pif.p8;
      ptr64k_o <= pif.p64;
    end
  end

  // ---------------------------------------------------------------
  // read mux, data one cycle after the strobe
  // ---------------------------------------------------------------
  wire [3:0] ra = reg_addr_i;
  wire [63:0] rmux =
    hit(ra, mtef_pkg::A_CTRL)  ? 64'(ctrl)     :
    hit(ra, mtef_pkg::A_BASE)  ? tbase         :
    hit(ra, mtef_pkg::A_EXT)   ? text          :
    hit(ra, mtef_pkg::A_CTX)   ? 64'(ctx)      :
    hit(ra, mtef_pkg::A_ISTAT) ? 64'(istat)    :
    hit(ra, mtef_pkg::A_DSTAT) ? 64'(dstat)    :
    hit(ra, mtef_pkg::A_DFAR)  ? dfar          :
    hit(ra, mtef_pkg::A_IRQ)   ? 64'(irq_st)   :
    hit(ra, mtef_pkg::A_MASK)  ? 64'(irq_mask) :
    hit(ra, mtef_pkg::A_SEL)   ? sel           :
    hit(ra, mtef_pkg::A_TLBD)  ? tlb_rd        : 64'h0;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) reg_rdata_o <= 64'h0;
    else reg_rdata_o <= reg_re_i ? rmux : 64'h0;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_bad_req;
    req_valid_i ##0 (over | (drop & issue));
  endsequence
  sequence s_flag_up;
    bus_req_o ##1 irq_st[mtef_pkg::IRQ_BAD];
  endsequence

  AST_BAD_FLAG: assert property (s_bad_req |=> s_flag_up)
    else $error("bad address flag not raised after bus request");
  AST_OVER_MISS: assert property (req_valid_i && over
    |=> bus_req_o && bus_cacheable_o)
    else $error("high cacheable address did not go to the bus");
  AST_NARROW: assert property (issue && !aw43
    |=> bus_addr_o[42:41] == 2'b00 &&
        bus_addr_o[40:0] == $past(req_pa_i[40:0]))
    else $error("narrow bus address wrong");
  AST_WIDE: assert property (issue && aw43
    |=> bus_addr_o == $past(req_pa_i))
    else $error("wide bus address wrong");
  AST_RSV: assert property (reg_re_i && hit(ra, mtef_pkg::A_TLBD)
    |=> reg_rdata_o[46:43] == 4'h0 &&
        !reg_rdata_o[mtef_pkg::CV_B])
    else $error("reserved or cache-virtual bit read nonzero");
  AST_SA_LOCK: assert property (reg_re_i && hit(ra, mtef_pkg::A_TLBD)
    && !sel[mtef_pkg::S_FA] |=> !reg_rdata_o[mtef_pkg::LOCK_B])
    else $error("set-associative lock bit read nonzero");
  AST_IAE: assert property (i_err |=> iae_trap_o &&
    istat[16:8] == mtef_pkg::TT_IAE)
    else $error("instruction access error not recorded");
  AST_DAE: assert property (d_err |=> dae_trap_o &&
    dfar == $past(d_va_i))
    else $error("data access error not recorded");
  AST_JUMP_AND_LINK_INSTR: assert property (d_misalign_i && d_jump_and_link_instr_ret_i && !d_err
    |=> $stable(dfar) && $stable(dstat))
    else $error("jump misalign changed data fault state");
  AST_UHIT: assert property (!i_ue_i && !i_buserr_i && !i_parity_i
    && i_utlb_hit_i |=> !iae_trap_o)
    else $error("multiple hit counted on micro TLB hit");
  AST_HOLD: assert property (!w_ctrl |=> $stable(aw43))
    else $error("width select changed without a write");
endmodule
`default_nettype wire

/* mtef_bus_model.sv */
`default_nettype none
module mtef_bus_model (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // bus side of the block
  input  wire logic        bus_req_i,
  input  wire logic [42:0] bus_addr_i,
  // test control and observation
  input  wire logic        err_arm_i,
  output logic             bus_err_o,
  output logic      [42:0] seen_addr_o,
  output logic      [7:0]  seen_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // transfer capture and error answer
  // ----------------------------------------------------------------
  // error answer comes one cycle after the transfer, like a slow target
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bus_err_o   <= 1'b0;
      seen_addr_o <= '0;
      seen_cnt_o  <= '0;
    end else begin
      bus_err_o <= bus_req_i & err_arm_i;
      if (bus_req_i) begin
        seen_addr_o <= bus_addr_i;
        seen_cnt_o  <= seen_cnt_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [63:0] RSV_M  = 64'h0000_7800_0000_0000;
  localparam logic [63:0] VIRT_M = 64'h0000_0000_0000_0010;
  logic        ref_clk_i, rst_n_i, reg_we_i, reg_re_i, tte_wr_i;
  logic        tte_side_i, req_valid_i, req_cach_i, l2_hit_i, err_arm;
  logic        err_side, bus_err, bus_req_o, bus_cach_o, irq_o, tr;
  logic        iae_trap_o, dae_trap_o;
  logic [1:0]  tte_idx_i;
  logic [3:0]  reg_addr_i;
  logic [7:0]  seen_cnt;
  logic [9:0]  errs;
  logic [36:0] l2_tag_o;
  logic [42:0] req_pa_i, bus_addr_o, seen_addr;
  logic [63:0] reg_wdata_i, reg_rdata_o, tte_data_i, d_va_i, va_i, rv;
  logic [63:0] ptr8k_o, ptr64k_o;
  int          mismatches, num_checks;

  mtef_mmu #(.FA_N(4), .SA_N(4)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .tte_wr_i(tte_wr_i),
    .tte_side_i(tte_side_i), .tte_idx_i(tte_idx_i),
    .tte_data_i(tte_data_i), .req_valid_i(req_valid_i),
    .req_pa_i(req_pa_i), .req_cacheable_i(req_cach_i),
    .l2_hit_i(l2_hit_i), .bus_req_o(bus_req_o), .bus_addr_o(bus_addr_o),
    .bus_cacheable_o(bus_cach_o), .l2_tag_o(l2_tag_o),
    .i_ue_i(errs[0]), .i_buserr_i(bus_err & ~err_side),
    .i_multi_i(errs[1]), .i_utlb_hit_i(errs[2]), .i_parity_i(errs[3]),
    .d_ue_i(errs[4]), .d_buserr_i(bus_err & err_side),
    .d_multi_i(errs[5]), .d_utlb_hit_i(errs[6]), .d_parity_i(errs[7]),
    .d_va_i(d_va_i), .d_misalign_i(errs[8]), .d_jump_and_link_instr_ret_i(errs[9]),
    .iae_trap_o(iae_trap_o), .dae_trap_o(dae_trap_o), .irq_o(irq_o),
    .va_i(va_i), .ptr8k_o(ptr8k_o), .ptr64k_o(ptr64k_o));

  mtef_bus_model pm (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_o),
    .bus_addr_i(bus_addr_o), .err_arm_i(err_arm), .bus_err_o(bus_err),
    .seen_addr_o(seen_addr), .seen_cnt_o(seen_cnt));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [63:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_we_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_we_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [63:0] e,
                     input string nm);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_re_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_re_i <= 1'b0;
    #1 rv = reg_rdata_o;
    chk(nm, e, rv);
  endtask

  task automatic tw(input logic s, input logic [1:0] ix,
                    input logic [63:0] d);
    @(posedge ref_clk_i);
    tte_wr_i   <= 1'b1;
    tte_side_i <= s;
    tte_idx_i  <= ix;
    tte_data_i <= d;
    @(posedge ref_clk_i);
    tte_wr_i <= 1'b0;
  endtask

  task automatic rq(input logic [42:0] pa, input logic c, h);
    @(posedge ref_clk_i);
    req_valid_i <= 1'b1;
    req_pa_i    <= pa;
    req_cach_i  <= c;
    l2_hit_i    <= h;
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
    #1;
  endtask

  // one-cycle error pulse, traps looked at in the cycle they stand
  task automatic ep(input logic [9:0] m, input logic it, dt);
    @(posedge ref_clk_i);
    errs <= m;
    @(posedge ref_clk_i);
    errs <= '0;
    #1;
    chk("iae_trap", 64'(it), 64'(iae_trap_o));
    chk("dae_trap", 64'(dt), 64'(dae_trap_o));
  endtask

  function automatic logic [63:0] ptr(input logic [63:0] e, v,
                                      input int n, lo);
    logic [63:0] m;
    m = (64'h1 << (9 + n)) - 64'h1;
    return (e & ~((64'h1 << (13 + n)) - 64'h1)) |
           ((((v >> lo) ^ 64'h1ABC) & m) << 4);
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdc(mtef_pkg::A_CTRL, 64'h1, "ctrl_reset");
    @(posedge ref_clk_i);
    #1 chk("rdata_once", 64'h0, reg_rdata_o);
    wr(4'hF, '1);
    rdc(4'hF, 64'h0, "unmapped");
    chk("bus_req_idle", 64'h0, 64'(bus_req_o));
    $display("test reset done");
  endtask

  task automatic t_entry();
    logic [63:0] d;
    d = 64'h8000_0000_1234_A040 | RSV_M | VIRT_M;
    tw(1'b1, 2'h1, d);
    wr(mtef_pkg::A_SEL, 64'h3);
    rdc(mtef_pkg::A_TLBD, d & ~(RSV_M | VIRT_M), "lock8k");
    d = 64'hA000_0000_0001_E000 | RSV_M | VIRT_M;
    tw(1'b1, 2'h0, d);
    wr(mtef_pkg::A_SEL, 64'h7);
    rdc(mtef_pkg::A_TLBD, d & ~(RSV_M | VIRT_M), "fa64k");
    d = 64'hC000_0000_0007_E000 | VIRT_M;
    tw(1'b1, 2'h3, d);
    wr(mtef_pkg::A_SEL, 64'hB);
    rdc(mtef_pkg::A_TLBD, d & ~VIRT_M, "fa512k");
    d = 64'hE000_0000_003F_E000 | RSV_M | VIRT_M;
    tw(1'b1, 2'h2, d);
    wr(mtef_pkg::A_SEL, 64'h9);
    rdc(mtef_pkg::A_TLBD, d & ~(RSV_M | VIRT_M), "sa4m");
    d = 64'h8000_0000_0055_6040;
    tw(1'b0, 2'h2, d);
    wr(mtef_pkg::A_SEL, 64'h2);
    rdc(mtef_pkg::A_TLBD, d, "ilock");
    $display("test entry done");
  endtask

  task automatic t_req();
    wr(mtef_pkg::A_MASK, 64'h7);
    rq(43'h3FF_FFFF_FFC0, 1'b1, 1'b1);
    chk("bus_req_hit", 64'h0, 64'(bus_req_o));
    chk("l2_tag", 64'h3FF_FFFF_FFC0 >> 6, 64'(l2_tag_o));
    rq(43'h400_0000_0000, 1'b1, 1'b1);
    chk("bus_req_lim", 64'h1, 64'(bus_req_o));
    chk("bus_cach", 64'h1, 64'(bus_cach_o));
    chk("bus_addr43", 64'h400_0000_0000, 64'(bus_addr_o));
    rdc(mtef_pkg::A_IRQ, 64'h4, "bad_lim");
    chk("irq_on", 64'h1, 64'(irq_o));
    wr(mtef_pkg::A_IRQ, 64'h4);
    wr(mtef_pkg::A_CTRL, 64'h0);
    rq(43'h600_0000_1234, 1'b0, 1'b0);
    chk("bus_addr41", 64'h1234, 64'(bus_addr_o));
    rdc(mtef_pkg::A_IRQ, 64'h4, "bad41");
    chk("far_addr", 64'h1234, 64'(seen_addr));
    wr(mtef_pkg::A_IRQ, 64'h4);
    rq(43'h1FF_FFFF_FFFF, 1'b0, 1'b0);
    chk("bus_addr41b", 64'h1FF_FFFF_FFFF, 64'(bus_addr_o));
    rdc(mtef_pkg::A_IRQ, 64'h0, "ok41");
    chk("irq_off", 64'h0, 64'(irq_o));
    chk("bus_count", 64'h3, 64'(seen_cnt));
    wr(mtef_pkg::A_CTRL, 64'h1);
    $display("test request done");
  endtask

  task automatic t_err();
    logic [9:0]  src[3] = '{10'h001, 10'h002, 10'h008};
    logic [4:0]  cb[3]  = '{5'h01, 5'h04, 5'h08};
    logic [8:0]  tt;
    logic [63:0] ds;
    for (int s = 0; s < 2; s++) begin
      tt = s ? mtef_pkg::TT_DAE : mtef_pkg::TT_IAE;
      for (int k = 0; k < 3; k++) begin
        @(posedge ref_clk_i) d_va_i <= 64'hF00 + 64'(k);
        ep(src[k] << (4 * s), s == 0, s == 1);
        rdc(s ? mtef_pkg::A_DSTAT : mtef_pkg::A_ISTAT,
            (64'(tt) << 8) | 64'(cb[k]), "stat");
        chk("stat_tt", 64'(tt), 64'(rv[16:8]));
        chk("stat_cause", 64'(cb[k]), 64'(rv[4:0] & cb[k]));
        if (s == 1) rdc(mtef_pkg::A_DFAR, 64'hF00 + 64'(k), "dfar");
      end
      // cause comes from the far side answering a transfer
      @(posedge ref_clk_i);
      err_side <= s[0];
      err_arm  <= 1'b1;
      tr       = 1'b0;
      rq(43'h100, 1'b0, 1'b0);
      for (int n = 0; n < 8 && tr !== 1'b1; n++) begin
        @(posedge ref_clk_i);
        #1 tr = s ? dae_trap_o : iae_trap_o;
      end
      @(posedge ref_clk_i) err_arm <= 1'b0;
      chk("bus_err_trap", 64'h1, 64'(tr));
      if (tr !== 1'b1) finish_test();
      rdc(s ? mtef_pkg::A_DSTAT : mtef_pkg::A_ISTAT,
          (64'(tt) << 8) | 64'h2, "stat");
      chk("bus_cause", 64'h2, 64'(rv[4:0] & 5'h02));
    end
    ep(10'h006, 1'b0, 1'b0);
    ep(10'h060, 1'b0, 1'b0);
    rdc(mtef_pkg::A_DSTAT, (64'(mtef_pkg::TT_DAE) << 8) | 64'h2,
        "dstat");
    ds = rv;
    @(posedge ref_clk_i) d_va_i <= 64'hBAD0;
    ep(10'h300, 1'b0, 1'b0);
    rdc(mtef_pkg::A_DSTAT, ds, "dstat_keep");
    rdc(mtef_pkg::A_DFAR, 64'hF02, "dfar_keep");
    ep(10'h100, 1'b0, 1'b0);
    rdc(mtef_pkg::A_DSTAT, (64'(mtef_pkg::TT_MIS) << 8) | 64'h10,
        "dstat_mis");
    rdc(mtef_pkg::A_DFAR, 64'hBAD0, "dfar_mis");
    chk("irq_err", 64'h1, 64'(irq_o));
    wr(mtef_pkg::A_MASK, 64'h0);
    rdc(mtef_pkg::A_IRQ, 64'h3, "irq_stat");
    chk("irq_masked", 64'h0, 64'(irq_o));
    wr(mtef_pkg::A_MASK, 64'h7);
    wr(mtef_pkg::A_IRQ, 64'h3);
    rdc(mtef_pkg::A_IRQ, 64'h0, "irq_clr");
    chk("irq_clr_o", 64'h0, 64'(irq_o));
    $display("test error done");
  endtask

  task automatic t_ptr();
    logic [63:0] e, v;
    e = 64'hFEDC_BA98_7654_3210;
    v = 64'h0000_1234_5678_9ABC;
    @(posedge ref_clk_i) va_i <= v;
    wr(mtef_pkg::A_BASE, '1);
    wr(mtef_pkg::A_EXT, e);
    wr(mtef_pkg::A_CTX, 64'h1ABC);
    // both ends of the size exponent range
    for (int n = 0; n < 16; n += 15) begin
      wr(mtef_pkg::A_CTRL, 64'h3 | (64'(n) << 2));
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk("ptr8k", ptr(e, v, n, 13), ptr8k_o);
      chk("ptr64k", ptr(e, v, n, 16), ptr64k_o);
    end
    $display("test pointer done");
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    mismatches++;
    $display("MISMATCH watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    {reg_we_i, reg_re_i, tte_wr_i, tte_side_i, req_valid_i} = '0;
    {req_cach_i, l2_hit_i, err_arm, err_side, tte_idx_i} = '0;
    {reg_addr_i, errs, req_pa_i, reg_wdata_i} = '0;
    {tte_data_i, d_va_i, va_i} = '0;
    mismatches = 0;
    num_checks = 0;
    rst_n_i = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_entry();
    t_req();
    t_err();
    t_ptr();
    finish_test();
  end
endmodule
`default_nettype wire
